// >>> hdl/dpbc_command_unit.sv
// command execution: power modes, auto power-down, sector buffer, identify, reset
// Overview of operation
// - E0 enters standby at once, E1 enters idle at once.
// - E2/E3 also enable power-down timer if sector count non-zero, else disable.
// - E5 writes FF to sector count when idle, 00 otherwise.
// - E6 spins down and sleeps at once, waits for stop, then interrupts.
// - other power commands interrupt as soon as spin sequence starts.
// - no spin-up when already idle, no spin-down when already standby.
// - timer counts sector count times 5 s, then enters standby.
// - timeout count is clamped to 12 through 220.
// - host reset only wakes a sleeping drive, into standby.
// - power-up state is idle by default.
// - a feature input selects standby as the power-up state.
// - E4 readies buffer for host reads, sets data request, interrupts.
// - E8 readies buffer for host writes, sets data request, interrupts.
// - EC fills buffer with parameter words, sets data request, interrupts.
// - word 0 is 0C5A, serial, firmware, model fields; reserved zero.
// - feature word reports prefetch, translate, no multiple, 15 s minimum.
// - EF with AA enables prefetch, 55 disables, else abort; on at reset.
// - motor-control option: low diag line blocks timeout and standby, spins up.
// - by default the diag line keeps its self-test pass meaning.
// - power sense, host reset and software resets set busy until released.
// - after reset, load defaults then clear busy with no interrupt.
// - defaults: error 01, count 01, number 01, cylinders 00, drive/head 00.
// - while busy, task file reads return status instead.
// - multiple read and write stay disabled after any reset.
module dpbc_command_unit
	import dpbc_pkg::*;
#(
	parameter longint UNIT_CYCLES = APD_UNIT_CYC,
	parameter int     INIT_CYCLES = 4,
	parameter int     FIFO_DEPTH  = 4,
	parameter logic [15:0] SERIAL_WORD = 16'h2020, // arbitrary
	parameter logic [15:0] FW_WORD     = 16'h3030, // arbitrary
	parameter logic [15:0] MODEL_WORD  = 16'h4141  // arbitrary
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   hostResetPin_n,
	input  wire logic                   softReset,
	input  wire logic                   cmdValid,
	input  wire dpbc_pkg::dpbc_cmd_type cmdIn,
	input  wire logic                   standbyAtPowerUp,
	input  wire logic                   motorCtrlEnable,
	input  wire logic                   diagPassLineIn,
	input  wire logic                   spindleStopped,
	input  wire logic                   taskRead,
	input  wire logic [2:0]             taskReadAddr,
	input  wire logic [7:0]             statusReg,
	output logic [7:0]                  taskReadData,
	output dpbc_pkg::dpbc_taskfile_type taskFile,
	output logic                        busy_flag,
	output logic                        data_request_flag,
	output logic                        intrq,
	output logic                        cmdAbort,
	output logic                        spinUpStart,
	output logic                        spinDownStart,
	output dpbc_pkg::dpbc_power_type    powerMode,
	output logic                        prefetch_read,
	output logic                        multiEnable,
	output logic                        diagPassOut,
	input  wire logic                   hostWrValid,
	input  wire logic [15:0]            hostWrData,
	output logic                        hostWrReady,
	output logic                        hostRdValid,
	output logic [15:0]                 hostRdData,
	input  wire logic                   hostRdReady,
	input  wire logic                   slavePassed
);
	typedef enum logic [2:0] {
		ST_INIT, ST_READY, ST_SLEEPWAIT, ST_FILL, ST_XFER_RD, ST_XFER_WR
	} dpbc_seq_type;

	logic [15:0]       buffer [BUF_WORDS];
	logic              hostRst1_q, hostRst2_q, diag1_q, diag2_q, hostRstPrev_q;
	logic              hostRstEdge;
	logic              powerUpDone_q;
	dpbc_seq_type      seq_q;
	dpbc_power_type    pwr_q;
	logic [7:0]        initCnt_q;
	logic [8:0]        idx_q;
	logic              apdEnable_q;
	logic [7:0]        apdUnits_q, apdLeft_q;
	logic [39:0]       unitCnt_q;
	logic              motorHold;
	logic              cmdTake;
	logic [7:0]        clampCount;
	logic              fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
	logic [15:0]       fifoInData, fifoOutData;
	logic [15:0]       identWord;
	dpbc_taskfile_type tf_q;

	// two-flop synchronisers for pins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hostRst1_q <= 1'b1;
			hostRst2_q <= 1'b1;
			diag1_q    <= 1'b1;
			diag2_q    <= 1'b1;
			hostRstPrev_q <= 1'b1;
		end else begin
			hostRst1_q <= hostResetPin_n;
			hostRst2_q <= hostRst1_q;
			diag1_q    <= diagPassLineIn;
			diag2_q    <= diag1_q;
			hostRstPrev_q <= hostRst2_q;
		end
	end
	assign hostRstEdge = hostRstPrev_q && !hostRst2_q;

	// low diag line holds spindle when option on
	assign motorHold = motorCtrlEnable && !diag2_q;
	// default role: report slave self-test result
	assign diagPassOut = motorCtrlEnable ? 1'b1 : slavePassed;

	assign cmdTake = cmdValid && seq_q == ST_READY;

	always_comb begin
		if (cmdIn.sectCount < APD_MIN) begin
			clampCount = APD_MIN;
		end else if (cmdIn.sectCount > APD_MAX) begin
			clampCount = APD_MAX;
		end else begin
			clampCount = cmdIn.sectCount;
		end
	end

	// any reset source holds busy; software bit persists while set
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seq_q     <= ST_INIT;
			initCnt_q <= '0;
			idx_q     <= '0;
		end else if (!hostRst2_q || softReset) begin
			seq_q     <= ST_INIT;
			initCnt_q <= '0;
		end else begin
			unique case (seq_q)
				ST_INIT: begin
					initCnt_q <= initCnt_q + 1'b1;
					if (initCnt_q == 8'(INIT_CYCLES - 1)) begin
						seq_q <= ST_READY;
					end
				end
				ST_READY: begin
					idx_q <= '0;
					if (cmdTake) begin
						unique case (cmdIn.command)
							CMD_SLEEP:    seq_q <= ST_SLEEPWAIT;
							CMD_IDENTIFY: seq_q <= ST_FILL;
							CMD_READ_BUF: seq_q <= ST_XFER_RD;
							CMD_WRITE_BUF: seq_q <= ST_XFER_WR;
							default:      seq_q <= ST_READY;
						endcase
					end
				end
				ST_SLEEPWAIT: begin
					if (spindleStopped) begin
						seq_q <= ST_READY;
					end
				end
				ST_FILL: begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == 9'(BUF_WORDS - 1)) begin
						seq_q <= ST_XFER_RD;
						idx_q <= '0;
					end
				end
				ST_XFER_RD: begin
					if (fifoInValid && fifoInReady) begin
						idx_q <= idx_q + 1'b1;
					end
					if (idx_q == 9'(BUF_WORDS) && !fifoOutValid) begin
						seq_q <= ST_READY;
					end
				end
				ST_XFER_WR: begin
					if (fifoOutValid) begin
						idx_q <= idx_q + 1'b1;
						if (idx_q == 9'(BUF_WORDS - 1)) begin
							seq_q <= ST_READY;
						end
					end
				end
			endcase
		end
	end

	// busy only during reset init, fill and sleep wait
	assign busy_flag = seq_q == ST_INIT || seq_q == ST_FILL || seq_q == ST_SLEEPWAIT;
	assign data_request_flag = seq_q == ST_XFER_RD || seq_q == ST_XFER_WR;

	always_comb begin
		identWord = '0;
		if (idx_q == 9'd0) begin
			identWord = ID_SIGNATURE;
		end else if (idx_q >= 9'(ID_SERIAL_LO) && idx_q <= 9'(ID_SERIAL_HI)) begin
			identWord = SERIAL_WORD;
		end else if (idx_q >= 9'(ID_FW_LO) && idx_q <= 9'(ID_FW_HI)) begin
			identWord = FW_WORD;
		end else if (idx_q >= 9'(ID_MODEL_LO) && idx_q <= 9'(ID_MODEL_HI)) begin
			identWord = MODEL_WORD;
		end else if (idx_q == 9'(ID_FEATURE_W)) begin
			identWord[FEAT_PREFETCH]  = prefetch_read;
			identWord[FEAT_TRANSLATE] = 1'b1;
			identWord[FEAT_NO_MULTI]  = 1'b1;
			identWord[FEAT_MIN_TO15]  = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (seq_q == ST_FILL) begin
			buffer[idx_q[7:0]] <= identWord;
		end else if (seq_q == ST_XFER_WR && fifoOutValid) begin
			buffer[idx_q[7:0]] <= fifoOutData;
		end
	end

	// read path streams buffer words to the host; write path drains host words into the buffer
	assign fifoInValid  = seq_q == ST_XFER_RD ? idx_q < 9'(BUF_WORDS) :
		hostWrValid && seq_q == ST_XFER_WR;
	assign fifoInData   = seq_q == ST_XFER_RD ? buffer[idx_q[7:0]] : hostWrData;
	assign fifoOutReady = seq_q == ST_XFER_RD ? hostRdReady : seq_q == ST_XFER_WR;
	assign hostWrReady  = seq_q == ST_XFER_WR && fifoInReady;
	assign hostRdValid  = seq_q == ST_XFER_RD && fifoOutValid;
	assign hostRdData   = fifoOutData;

	dpbc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.flush    (seq_q == ST_READY),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// power state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q         <= PWR_IDLE;
			powerUpDone_q <= 1'b0;
			spinUpStart   <= 1'b0;
			spinDownStart <= 1'b0;
		end else begin
			spinUpStart   <= 1'b0;
			spinDownStart <= 1'b0;
			if (!powerUpDone_q) begin
				powerUpDone_q <= 1'b1;
				// power-up mode strap caught after release
				if (standbyAtPowerUp) begin
					pwr_q <= PWR_STANDBY;
				end else begin
					pwr_q         <= PWR_IDLE;
					spinUpStart   <= 1'b1;
				end
			end else if (hostRstEdge) begin
				// host reset only wakes sleep, into standby
				if (pwr_q == PWR_SLEEP) begin
					pwr_q <= PWR_STANDBY;
				end
			end else if (cmdTake && (cmdIn.command == CMD_STANDBY ||
					cmdIn.command == CMD_STANDBY_APD || cmdIn.command == CMD_SLEEP)) begin
				// spin down only if not already stopped
				spinDownStart <= pwr_q == PWR_IDLE;
				pwr_q         <= cmdIn.command == CMD_SLEEP ? PWR_SLEEP : PWR_STANDBY;
			end else if (cmdTake && (cmdIn.command == CMD_IDLE ||
					cmdIn.command == CMD_IDLE_APD)) begin
				spinUpStart <= pwr_q != PWR_IDLE;
				pwr_q       <= PWR_IDLE;
			end else if (motorHold && pwr_q == PWR_STANDBY) begin
				// motor line spins the disk up
				spinUpStart <= 1'b1;
				pwr_q       <= PWR_IDLE;
			end else if (apdEnable_q && pwr_q == PWR_IDLE && !motorHold &&
					apdLeft_q == '0) begin
				spinDownStart <= 1'b1;
				pwr_q         <= PWR_STANDBY;
			end
		end
	end
	assign powerMode = pwr_q;

	// auto power-down timer, 5 s unit pulses
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			apdEnable_q <= 1'b0;
			apdUnits_q  <= APD_MIN;
			apdLeft_q   <= APD_MIN;
			unitCnt_q   <= '0;
		end else if (cmdTake) begin
			unitCnt_q <= '0;
			if (cmdIn.command == CMD_STANDBY_APD || cmdIn.command == CMD_IDLE_APD) begin
				apdEnable_q <= cmdIn.sectCount != '0;
				apdUnits_q  <= clampCount;
				apdLeft_q   <= clampCount;
			end else begin
				apdLeft_q <= apdUnits_q;
			end
		end else if (pwr_q != PWR_IDLE || motorHold) begin
			apdLeft_q <= apdUnits_q;
			unitCnt_q <= '0;
		end else if (apdEnable_q && apdLeft_q != '0) begin
			if (unitCnt_q == 40'(UNIT_CYCLES - 1)) begin
				unitCnt_q <= '0;
				apdLeft_q <= apdLeft_q - 1'b1;
			end else begin
				unitCnt_q <= unitCnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prefetch_read <= 1'b1;
			cmdAbort      <= 1'b0;
		end else if (seq_q == ST_INIT) begin
			prefetch_read <= 1'b1;
			cmdAbort      <= 1'b0;
		end else if (cmdTake && cmdIn.command == CMD_PREFETCH) begin
			cmdAbort <= 1'b0;
			if (cmdIn.precomp == PREFETCH_ON) begin
				prefetch_read <= 1'b1;
			end else if (cmdIn.precomp == PREFETCH_OFF) begin
				prefetch_read <= 1'b0;
			end else begin
				cmdAbort <= 1'b1;
			end
		end else if (cmdTake) begin
			cmdAbort <= 1'b0;
		end
	end
	assign multiEnable = 1'b0;

	// task file and interrupts
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tf_q  <= '0;
			intrq <= 1'b0;
		end else if (seq_q == ST_INIT) begin
			tf_q  <= '{RST_ERROR, RST_SECT_COUNT, RST_SECT_NUM, RST_CYL_LOW, RST_CYL_HIGH,
				RST_DRIVE_HEAD};
			intrq <= 1'b0;
		end else begin
			intrq <= 1'b0;
			if (cmdTake) begin
				tf_q.sectCount <= cmdIn.sectCount;
				intrq <= cmdIn.command != CMD_SLEEP && cmdIn.command != CMD_IDENTIFY;
				if (cmdIn.command == CMD_CHECK_POWER) begin
					tf_q.sectCount <= pwr_q == PWR_IDLE ? POWER_IDLE_ANS : POWER_STBY_ANS;
				end
				if (cmdIn.command == CMD_PREFETCH && cmdIn.precomp != PREFETCH_ON &&
						cmdIn.precomp != PREFETCH_OFF) begin
					tf_q.error <= ERR_ABORT;
				end
			end else if (seq_q == ST_SLEEPWAIT && spindleStopped) begin
				intrq <= 1'b1;
			end else if (seq_q == ST_FILL && idx_q == 9'(BUF_WORDS - 1)) begin
				intrq <= 1'b1;
			end
		end
	end
	assign taskFile = tf_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			taskReadData <= '0;
		end else if (taskRead) begin
			if (busy_flag) begin
				taskReadData <= statusReg;
			end else begin
				unique case (taskReadAddr)
					3'h1: taskReadData <= tf_q.error;
					3'h2: taskReadData <= tf_q.sectCount;
					3'h3: taskReadData <= tf_q.sectNum;
					3'h4: taskReadData <= tf_q.cylLow;
					3'h5: taskReadData <= tf_q.cylHigh;
					3'h6: taskReadData <= tf_q.driveHead;
					default: taskReadData <= statusReg;
				endcase
			end
		end
	end

	a_busy_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		taskRead && busy_flag |=> taskReadData == $past(statusReg))
		else $error("busy read did not return status");
	a_check_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_CHECK_POWER && pwr_q == PWR_IDLE
		|=> tf_q.sectCount == POWER_IDLE_ANS)
		else $error("power query answer wrong");
	a_no_spinup_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_IDLE && pwr_q == PWR_IDLE |=> !spinUpStart)
		else $error("spin-up while idle");
	a_standby_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_STANDBY && !hostRstEdge
		|=> pwr_q == PWR_STANDBY && intrq)
		else $error("standby command not obeyed");
	a_sleep_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
		seq_q == ST_SLEEPWAIT && !spindleStopped && hostRst2_q && !softReset
		|=> !intrq && seq_q == ST_SLEEPWAIT)
		else $error("sleep interrupt before stop");
	a_apd_clamp: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_IDLE_APD && cmdIn.sectCount == 8'h01
		|=> apdUnits_q == APD_MIN && apdEnable_q)
		else $error("timeout clamp failed");
	a_prefetch_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_PREFETCH && cmdIn.precomp == PREFETCH_OFF
		|=> !prefetch_read && !cmdAbort)
		else $error("prefetch disable failed");
	a_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		seq_q == ST_INIT |=> !intrq)
		else $error("interrupt during reset init");
	a_wake_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hostRstEdge && pwr_q == PWR_SLEEP && powerUpDone_q |=> pwr_q == PWR_STANDBY)
		else $error("sleep wake not to standby");
	c_identify: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmdTake && cmdIn.command == CMD_IDENTIFY ##[1:300] seq_q == ST_XFER_RD);
	c_sleep: cover property (@(posedge clk_sys) disable iff (!rst_n)
		seq_q == ST_SLEEPWAIT ##1 intrq);
	c_write_buf: cover property (@(posedge clk_sys) disable iff (!rst_n)
		seq_q == ST_XFER_WR && hostWrReady);
endmodule

// >>> inc/dpbc_pkg.sv
// shared constants and carrier types for the disk power and buffer command unit
package dpbc_pkg;
	localparam logic [7:0] CMD_STANDBY     = 8'hE0;
	localparam logic [7:0] CMD_IDLE        = 8'hE1;
	localparam logic [7:0] CMD_STANDBY_APD = 8'hE2;
	localparam logic [7:0] CMD_IDLE_APD    = 8'hE3;
	localparam logic [7:0] CMD_READ_BUF    = 8'hE4;
	localparam logic [7:0] CMD_CHECK_POWER = 8'hE5;
	localparam logic [7:0] CMD_SLEEP       = 8'hE6;
	localparam logic [7:0] CMD_WRITE_BUF   = 8'hE8;
	localparam logic [7:0] CMD_IDENTIFY    = 8'hEC;
	localparam logic [7:0] CMD_PREFETCH    = 8'hEF;
	localparam logic [7:0] PREFETCH_ON     = 8'hAA;
	localparam logic [7:0] PREFETCH_OFF    = 8'h55;
	localparam logic [7:0] POWER_IDLE_ANS  = 8'hFF;
	localparam logic [7:0] POWER_STBY_ANS  = 8'h00;
	localparam logic [7:0] ERR_ABORT       = 8'h04;
	// register defaults loaded after reset
	localparam logic [7:0] RST_ERROR       = 8'h01;
	localparam logic [7:0] RST_SECT_COUNT  = 8'h01;
	localparam logic [7:0] RST_SECT_NUM    = 8'h01;
	localparam logic [7:0] RST_CYL_LOW     = 8'h00;
	localparam logic [7:0] RST_CYL_HIGH    = 8'h00;
	localparam logic [7:0] RST_DRIVE_HEAD  = 8'h00;
	// power-down timeout clamp, units of 5 s
	localparam logic [7:0] APD_MIN         = 8'h0C;
	localparam logic [7:0] APD_MAX         = 8'hDC;
	localparam int         APD_UNIT_S      = 5;
	localparam longint     CLK_HZ          = 250000000;
	localparam longint     APD_UNIT_CYC    = APD_UNIT_S * CLK_HZ;
	// identify block layout
	localparam int         ID_WORDS        = 256;
	localparam logic [15:0] ID_SIGNATURE   = 16'h0C5A;
	localparam int         ID_SERIAL_LO    = 10;
	localparam int         ID_SERIAL_HI    = 19;
	localparam int         ID_FW_LO        = 23;
	localparam int         ID_FW_HI        = 26;
	localparam int         ID_MODEL_LO     = 27;
	localparam int         ID_MODEL_HI     = 46;
	localparam int         ID_FEATURE_W    = 132;
	localparam int         FEAT_PREFETCH   = 14;
	localparam int         FEAT_TRANSLATE  = 12;
	localparam int         FEAT_NO_MULTI   = 11;
	localparam int         FEAT_MIN_TO15   = 1;
	localparam int         BUF_BYTES       = 512;
	localparam int         BUF_WORDS       = BUF_BYTES / 2;

	typedef enum logic [1:0] {
		PWR_IDLE,
		PWR_STANDBY,
		PWR_SLEEP
	} dpbc_power_type;

	typedef struct packed {
		logic [7:0] command;
		logic [7:0] sectCount;
		logic [7:0] precomp;
	} dpbc_cmd_type;

	typedef struct packed {
		logic [7:0] error;
		logic [7:0] sectCount;
		logic [7:0] sectNum;
		logic [7:0] cylLow;
		logic [7:0] cylHigh;
		logic [7:0] driveHead;
	} dpbc_taskfile_type;
endpackage

// >>> hdl/dpbc_fifo.sv
// small valid/ready FIFO for the sector data path
module dpbc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign outData  = mem[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> testbench/dpbc_host_model.sv
// host side: drains sector buffer words in stalling bursts, writes one sector of counted words
module dpbc_host_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hostRdValid,
	input  wire logic [15:0] hostRdData,
	output logic             hostRdReady,
	output logic             hostWrValid,
	output logic [15:0]      hostWrData,
	input  wire logic        hostWrReady,
	output int               rdCount,
	output logic [15:0]      word0,
	output logic [15:0]      word132
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] phaseQ;
	int         wrCount;
	// long stalls let the four-word fifo fill and refuse
	always @(negedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phaseQ <= 4'h0;
			hostRdReady <= 1'b0;
			hostWrValid <= 1'b0;
			hostWrData <= 16'hA5A5;
		end else begin
			phaseQ <= phaseQ + 4'h1;
			hostRdReady <= phaseQ[3];
			// one sector only; each word stands until the unit takes it
			hostWrValid <= wrCount < 256;
			hostWrData <= 16'hA5A5 ^ wrCount[15:0];
		end
	end
	// host counts every word read, across all sectors
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdCount <= 0;
			wrCount <= 0;
		end else begin
			if (hostWrValid && hostWrReady) wrCount <= wrCount + 1;
			if (hostRdValid && hostRdReady) begin
				if (rdCount[7:0] == 8'h00) word0 <= hostRdData;
				if (rdCount[7:0] == 8'h84) word132 <= hostRdData;
				rdCount <= rdCount + 1;
			end
		end
	end
endmodule

// >>> testbench/tb.sv
// self-checking bench for the power and buffer command unit
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dpbc_pkg::*;
	logic clk_sys = 0, rst_n = 0, hostResetPin_n = 1, softReset = 0, cmdValid = 0;
	logic spindleStopped = 0, taskRead = 0, slavePassed = 1, hostRdReady;
	logic strap = 0, motorEn = 0, diagLine = 1;
	logic [2:0] taskReadAddr = 3'h0;
	logic [7:0] taskReadData, statusReg = 8'hD0;
	dpbc_cmd_type cmdIn = '0;
	dpbc_taskfile_type taskFile;
	dpbc_power_type powerMode;
	logic busy_flag, data_request_flag, intrq, cmdAbort, spinUpStart, spinDownStart;
	logic prefetch_read, multiEnable, diagPassOut, hostWrValid, hostWrReady, hostRdValid;
	logic [15:0] hostRdData, hostWrData, word0, word132;
	logic sawUp = 0, sawDown = 0, sawInt = 0;
	int rdCount, base, errors = 0, n_checks = 0;
	logic [7:0] pv [3] = '{8'hAA, 8'h55, 8'h33};
	logic pfx [3] = '{1'b1, 1'b0, 1'b0};
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (spinUpStart === 1'b1) sawUp = 1;
		if (spinDownStart === 1'b1) sawDown = 1;
		if (intrq === 1'b1) sawInt = 1;
	end
	dpbc_command_unit #(.UNIT_CYCLES(10)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.hostResetPin_n(hostResetPin_n), .softReset(softReset), .cmdValid(cmdValid),
		.cmdIn(cmdIn), .standbyAtPowerUp(strap), .motorCtrlEnable(motorEn),
		.diagPassLineIn(diagLine), .spindleStopped(spindleStopped), .taskRead(taskRead),
		.taskReadAddr(taskReadAddr), .statusReg(statusReg), .taskReadData(taskReadData),
		.taskFile(taskFile), .busy_flag(busy_flag), .data_request_flag(data_request_flag),
		.intrq(intrq), .cmdAbort(cmdAbort), .spinUpStart(spinUpStart),
		.spinDownStart(spinDownStart), .powerMode(powerMode), .prefetch_read(prefetch_read),
		.multiEnable(multiEnable), .diagPassOut(diagPassOut), .hostWrValid(hostWrValid),
		.hostWrData(hostWrData), .hostWrReady(hostWrReady), .hostRdValid(hostRdValid),
		.hostRdData(hostRdData), .hostRdReady(hostRdReady), .slavePassed(slavePassed));
	dpbc_host_model host_u (.clk_sys(clk_sys), .rst_n(rst_n), .hostRdValid(hostRdValid),
		.hostRdData(hostRdData), .hostRdReady(hostRdReady), .hostWrData(hostWrData),
		.hostWrValid(hostWrValid), .hostWrReady(hostWrReady), .rdCount(rdCount),
		.word0(word0), .word132(word132));
	task automatic final_report;
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic waitFor(input int lim, ref logic sig, input string m);
		int i;
		i = 0;
		while (sig !== 1'b1 && i < lim) begin
			cyc(1);
			i++;
		end
		chk(sig, m);
		if (sig !== 1'b1) final_report();
	endtask
	task automatic waitIdle;
		int i;
		for (i = 0; i < 300 && busy_flag !== 1'b0; i++) cyc(1);
		chk(busy_flag === 1'b0, "busy stuck");
		if (busy_flag !== 1'b0) final_report();
	endtask
	task automatic cmd(input logic [7:0] c, s, p, input int lim);
		waitIdle();
		sawUp = 0;
		sawDown = 0;
		sawInt = 0;
		cmdIn = '{c, s, p};
		cmdValid = 1;
		cyc(1);
		cmdValid = 0;
		if (lim > 0) waitFor(lim, sawInt, "no interrupt");
	endtask
	task automatic rdReg(input logic [2:0] a, input logic [7:0] exp, input string m);
		taskReadAddr = a;
		taskRead = 1;
		cyc(1);
		taskRead = 0;
		chk(taskReadData === exp, m);
	endtask
	task automatic drain(input logic [15:0] exp0);
		int i;
		for (i = 0; i < 3000 && rdCount < base + 256; i++) cyc(1);
		chk(rdCount === base + 256 && word0 === exp0, "buffer words");
		if (rdCount !== base + 256) final_report();
		cyc(4);
		chk(data_request_flag === 1'b0, "data request left set");
		base = rdCount;
	endtask
	initial begin
		base = 0;
		cyc(5);
		rst_n = 1;
		cyc(1);
		chk(busy_flag === 1'b1, "busy not set at init");
		waitIdle();
		chk(sawInt === 1'b0 && taskFile === 48'h010101000000, "reset defaults");
		chk(powerMode === PWR_IDLE && prefetch_read === 1'b1, "power-up state");
		chk(multiEnable === 1'b0, "multiple enabled");
		slavePassed = 0;
		cyc(1);
		chk(diagPassOut === 1'b0, "diag line role");
		slavePassed = 1;
		cmd(CMD_IDENTIFY, 8'h00, 8'h00, 400);
		chk(data_request_flag === 1'b1, "identify data request");
		drain(16'h0C5A);
		chk(word132 === 16'h5802, "feature word");
		cmd(CMD_READ_BUF, 8'h00, 8'h00, 5);
		chk(data_request_flag === 1'b1, "read buffer data request");
		drain(16'h0C5A);
		cmd(CMD_WRITE_BUF, 8'h00, 8'h00, 5);
		chk(data_request_flag === 1'b1, "write buffer data request");
		for (int i = 0; i < 600 && data_request_flag !== 1'b0; i++) cyc(1);
		chk(data_request_flag === 1'b0, "write buffer not filled");
		if (data_request_flag !== 1'b0) final_report();
		// host wrote A5A5 xor the word index
		cmd(CMD_READ_BUF, 8'h00, 8'h00, 5);
		drain(16'hA5A5);
		chk(word132 === 16'hA521, "written word");
		cmd(CMD_IDLE, 8'h00, 8'h00, 5);
		chk(sawUp === 1'b0, "spin-up while idle");
		cmd(CMD_STANDBY, 8'h00, 8'h00, 5);
		chk(sawDown === 1'b1 && powerMode === PWR_STANDBY, "standby entry");
		cmd(CMD_STANDBY, 8'h00, 8'h00, 5);
		chk(sawDown === 1'b0, "spin-down while standby");
		cmd(CMD_CHECK_POWER, 8'h00, 8'h00, 5);
		rdReg(3'h2, 8'h00, "check power standby");
		cmd(CMD_IDLE, 8'h00, 8'h00, 5);
		chk(sawUp === 1'b1 && powerMode === PWR_IDLE, "idle entry");
		cmd(CMD_CHECK_POWER, 8'h00, 8'h00, 5);
		chk(taskFile.sectCount === 8'hFF, "check power idle");
		for (int k = 0; k < 3; k++) begin
			cmd(CMD_PREFETCH, 8'h00, pv[k], 5);
			chk(prefetch_read === pfx[k] && cmdAbort === (k == 2), "prefetch");
		end
		cmd(CMD_PREFETCH, 8'h00, 8'hAA, 5);
		// count 1 clamps to 12 units of 10 cycles
		cmd(CMD_IDLE_APD, 8'h01, 8'h00, 5);
		cyc(60);
		// a command part way through restarts the full interval
		cmd(CMD_IDLE, 8'h00, 8'h00, 5);
		cyc(100);
		chk(powerMode === PWR_IDLE, "timeout too early");
		for (int i = 0; i < 60 && powerMode !== PWR_STANDBY; i++) cyc(1);
		chk(powerMode === PWR_STANDBY, "no auto standby");
		if (powerMode !== PWR_STANDBY) final_report();
		motorEn = 1;
		diagLine = 0;
		sawUp = 0;
		cyc(5);
		chk(sawUp === 1'b1 && powerMode === PWR_IDLE, "motor line spin-up");
		cyc(200);
		chk(powerMode === PWR_IDLE, "timeout not held");
		motorEn = 0;
		diagLine = 1;
		cmd(CMD_SLEEP, 8'h00, 8'h00, 0);
		cyc(30);
		chk(sawInt === 1'b0, "sleep answered before stop");
		spindleStopped = 1;
		waitFor(10, sawInt, "sleep interrupt");
		chk(powerMode === PWR_SLEEP, "not sleeping");
		hostResetPin_n = 0;
		cyc(5);
		hostResetPin_n = 1;
		waitIdle();
		chk(powerMode === PWR_STANDBY, "wake state");
		softReset = 1;
		cyc(4);
		chk(busy_flag === 1'b1, "soft reset busy");
		rdReg(3'h2, 8'hD0, "busy read not status");
		softReset = 0;
		waitIdle();
		rdReg(3'h1, 8'h01, "error default");
		strap = 1;
		rst_n = 0;
		cyc(2);
		rst_n = 1;
		waitIdle();
		chk(powerMode === PWR_STANDBY, "strap power-up state");
		final_report();
	end
endmodule
